// file: core/icl_defines.svh
`ifndef ICL_DEFINES_SVH
`define ICL_DEFINES_SVH

// register bus
`define ICL_ADDR_W 5
`define ICL_DATA_W 32
`define ICL_OFF_CTRL 5'h00
`define ICL_OFF_OPT 5'h04
`define ICL_OFF_TMR 5'h08
`define ICL_OFF_EVT 5'h0C
`define ICL_OFF_MASK 5'h10
`define ICL_OFF_CORE 5'h14
`define ICL_RESP_OKAY 2'h0
`define ICL_RESP_SLVERR 2'h2

// irq_control_reg fields
`define ICL_B_PCF 0
`define ICL_B_EXF 1
`define ICL_B_TOF 2
`define ICL_B_PCE 3
`define ICL_B_EXE 4
`define ICL_B_TOE 5
`define ICL_B_GIE 7

// option register fields
`define ICL_B_TRUN 0
`define ICL_B_EDGE 6

// event status and mask fields
`define ICL_EV_W 4
`define ICL_EV_EXT 0
`define ICL_EV_TOV 1
`define ICL_EV_PCH 2
`define ICL_EV_WAKE 3

// reset values and timer maximum
`define ICL_CTRL_RST 8'h00
`define ICL_OPT_RST 8'h41
`define ICL_TMR_RST 8'h00
`define ICL_MASK_RST 4'h0
`define ICL_TMR_MAX 8'hFF

// widths
`define ICL_PC_W 13
`define ICL_PORT_W 4

`endif

// file: core/icl_pkg.sv
`include "icl_defines.svh"

package icl_pkg;

  typedef struct packed {
    logic sleep;
    logic irq_ack;
    logic retfie;
    logic [`ICL_PC_W-1:0] ret_pc;
  } icl_core_in_t;

  typedef struct packed {
    logic irq_req;
    logic wake;
    logic to_vector;
    logic push_valid;
    logic [`ICL_PC_W-1:0] push_pc;
  } icl_core_out_t;

  typedef struct packed {
    logic global_irq_enable;
    logic reserved6;
    logic timer_overflow_enable;
    logic ext_irq_enable;
    logic port_change_enable;
    logic timer_overflow_flag;
    logic ext_irq_flag;
    logic port_change_flag;
  } icl_ctrl_t;

  typedef enum logic [0:0] {
    ICL_AWAKE = 1'b0,
    ICL_ASLEEP = 1'b1
  } icl_slp_t;

endpackage

// file: core/icl_in_sync.sv
`timescale 1ns/10ps

module icl_in_sync #(
  parameter int W = 5
) (
  input wire logic clk, // core clock
  input wire logic rst, // async reset, active high
  input wire logic [W-1:0] din, // asynchronous inputs
  output logic [W-1:0] level, // filtered level
  output logic valid // level is trustworthy
);
  import icl_pkg::*;

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [1:0] fill_q;
  logic primed_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // wait until the chain holds real pin values
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fill_q <= 2'h0;
      primed_q <= 1'b0;
      valid <= 1'b0;
    end else begin
      if (fill_q != 2'h3) begin
        fill_q <= fill_q + 2'h1;
      end
      primed_q <= (fill_q == 2'h3);
      valid <= primed_q;
    end
  end

  // per bit: a change counts once stages two and three agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i] && fill_q == 2'h3) begin
          level[i] <= s3_q[i];
        end
      end
    end
  end

endmodule

// file: core/icl_top.sv
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "icl_defines.svh"

// Operation
// - external pin is edge sensitive; edge select one means rising, zero falling.
// - each selected edge on the external pin sets the external flag.
// - external interrupt requests service only while its enable is set.
// - external edge wakes the core if its enable was set before sleep.
// - after wake, branch to the vector only when the global enable is set.
// - timer rollover from its maximum to zero sets the timer overflow flag.
// - timer overflow interrupt is gated by its own enable bit.
// - any level change on the four upper port pins sets the change flag.
// - port change interrupt is gated by its own enable bit.
// - interrupt entry pushes only the return program counter.
module icl_top #(
  parameter int ADDR_W = `ICL_ADDR_W,
  parameter int PORT_W = `ICL_PORT_W
) (
  input wire logic clk, // core clock, 125 MHz
  input wire logic rst, // async reset, active high
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [`ICL_DATA_W-1:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [`ICL_DATA_W-1:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic ext_irq_pin, // external interrupt pin
  input wire logic [PORT_W-1:0] upper_port_pins, // port bits 7..4
  input wire icl_pkg::icl_core_in_t core_in, // from processor core
  output icl_pkg::icl_core_out_t core_out, // to processor core
  output logic irq // event interrupt, level
);
  import icl_pkg::*;

  localparam int SYNC_W = PORT_W + 1;

  // register index decode, shared by read and write paths
  function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] a);
    logic [2:0] idx;
    idx = 3'h7;
    case (a)
      `ICL_OFF_CTRL: idx = 3'h0;
      `ICL_OFF_OPT: idx = 3'h1;
      `ICL_OFF_TMR: idx = 3'h2;
      `ICL_OFF_EVT: idx = 3'h3;
      `ICL_OFF_MASK: idx = 3'h4;
      `ICL_OFF_CORE: idx = 3'h5;
      default: idx = 3'h7;
    endcase
    return idx;
  endfunction

  // register state
  icl_ctrl_t ctrl_q;
  icl_ctrl_t ctrl_d;
  logic edge_sel_q;
  logic timer_run_q;
  logic [7:0] tmr_q;
  logic [7:0] tmr_d;
  logic [`ICL_EV_W-1:0] evt_q;
  logic [`ICL_EV_W-1:0] evt_d;
  logic [`ICL_EV_W-1:0] evt_set;
  logic [`ICL_EV_W-1:0] mask_q;
  logic [`ICL_EV_W-1:0] mask_d;

  // bus state
  logic [ADDR_W-1:0] aw_addr_q;
  logic aw_full_q;
  logic aw_full_d;
  logic [7:0] w_byte_q;
  logic w_lane0_q;
  logic w_full_q;
  logic w_full_d;
  logic wr_fire;
  logic rd_fire;
  logic bvalid_d;
  logic rvalid_d;
  logic [2:0] wr_idx;
  logic wr_ok;

  // pin and event state
  logic [SYNC_W-1:0] lvl;
  logic lvl_valid;
  logic [SYNC_W-1:0] prev_q;
  logic ext_rise;
  logic ext_fall;
  logic ext_edge;
  logic port_chg;
  logic tmr_ovf;
  icl_slp_t slp_q;
  logic armed_q;
  logic wake_now;

  icl_in_sync #(
    .W(SYNC_W)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .din({upper_port_pins, ext_irq_pin}),
    .level(lvl),
    .valid(lvl_valid)
  );

  // ---------------- pin edge and change detection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_q <= '0;
    end else begin
      prev_q <= lvl;
    end
  end

  // one flag set per filtered change
  assign ext_rise = lvl_valid & lvl[0] & ~prev_q[0];
  assign ext_fall = lvl_valid & ~lvl[0] & prev_q[0];
  assign ext_edge = edge_sel_q ? ext_rise : ext_fall;
  // any change on upper port pins
  assign port_chg = lvl_valid & (|(lvl[SYNC_W-1:1] ^ prev_q[SYNC_W-1:1]));

  // ---------------- write channel
  assign wr_fire = aw_full_q & w_full_q & ~s_axi_bvalid;
  assign wr_idx = reg_index(aw_addr_q);
  assign wr_ok = wr_fire & w_lane0_q;
  assign aw_full_d = (aw_full_q & ~wr_fire) | (s_axi_awvalid & s_axi_awready);
  assign w_full_d = (w_full_q & ~wr_fire) | (s_axi_wvalid & s_axi_wready);
  assign bvalid_d = wr_fire | (s_axi_bvalid & ~s_axi_bready);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_full_q <= 1'b0;
      w_byte_q <= 8'h00;
      w_lane0_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ICL_RESP_OKAY;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_byte_q <= s_axi_wdata[7:0];
        w_lane0_q <= s_axi_wstrb[0];
      end
      s_axi_awready <= ~aw_full_d & ~bvalid_d;
      s_axi_wready <= ~w_full_d & ~bvalid_d;
      s_axi_bvalid <= bvalid_d;
      if (wr_fire) begin
        s_axi_bresp <= (wr_idx == 3'h7) ? `ICL_RESP_SLVERR : `ICL_RESP_OKAY;
      end
    end
  end

  // ---------------- read channel
  assign rd_fire = s_axi_arvalid & s_axi_arready;
  assign rvalid_d = rd_fire | (s_axi_rvalid & ~s_axi_rready);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `ICL_RESP_OKAY;
    end else begin
      s_axi_arready <= ~rvalid_d;
      s_axi_rvalid <= rvalid_d;
      if (rd_fire) begin
        s_axi_rresp <= `ICL_RESP_OKAY;
        s_axi_rdata <= '0;
        case (reg_index(s_axi_araddr))
          3'h0: s_axi_rdata[7:0] <= {ctrl_q[7], 1'b0, ctrl_q[5:0]};
          3'h1: begin
            s_axi_rdata[`ICL_B_EDGE] <= edge_sel_q;
            s_axi_rdata[`ICL_B_TRUN] <= timer_run_q;
          end
          3'h2: s_axi_rdata[7:0] <= tmr_q;
          3'h3: s_axi_rdata[`ICL_EV_W-1:0] <= evt_q;
          3'h4: s_axi_rdata[`ICL_EV_W-1:0] <= mask_q;
          3'h5: s_axi_rdata[1:0] <= {armed_q, slp_q == ICL_ASLEEP};
          default: s_axi_rresp <= `ICL_RESP_SLVERR;
        endcase
      end
    end
  end

  // ---------------- option register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      edge_sel_q <= 1'(`ICL_OPT_RST >> `ICL_B_EDGE);
      timer_run_q <= 1'(`ICL_OPT_RST >> `ICL_B_TRUN);
    end else if (wr_ok && wr_idx == 3'h1) begin
      edge_sel_q <= w_byte_q[`ICL_B_EDGE];
      timer_run_q <= w_byte_q[`ICL_B_TRUN];
    end
  end

  // ---------------- eight bit timer
  // overflow only on an increment from the maximum
  assign tmr_ovf = timer_run_q & (tmr_q == `ICL_TMR_MAX) &
    ~(wr_ok && wr_idx == 3'h2);

  always_comb begin
    tmr_d = tmr_q;
    if (wr_ok && wr_idx == 3'h2) begin
      tmr_d = w_byte_q;
    end else if (timer_run_q) begin
      tmr_d = tmr_q + 8'h01;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tmr_q <= `ICL_TMR_RST;
    end else begin
      tmr_q <= tmr_d;
    end
  end

  // ---------------- interrupt control register
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ok && wr_idx == 3'h0) begin
      ctrl_d = icl_ctrl_t'(w_byte_q);
      ctrl_d.reserved6 = 1'b0;
    end
    // flags fall only by software write
    // external edge sets its flag, set wins
    if (ext_edge) begin
      ctrl_d.ext_irq_flag = 1'b1;
    end
    if (tmr_ovf) begin
      ctrl_d.timer_overflow_flag = 1'b1;
    end
    if (port_chg) begin
      ctrl_d.port_change_flag = 1'b1;
    end
    if (core_in.retfie) begin
      ctrl_d.global_irq_enable = 1'b1;
    end
    if (core_in.irq_ack) begin
      ctrl_d.global_irq_enable = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= icl_ctrl_t'(`ICL_CTRL_RST);
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ---------------- core request and context push
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_out.irq_req <= 1'b0;
      core_out.push_valid <= 1'b0;
      core_out.push_pc <= '0;
    end else begin
      // global enable and any enabled pending source
      // external source gated by its enable
      // timer source gated by its enable
      // port source gated by its enable
      core_out.irq_req <= ctrl_d.global_irq_enable &
        ((ctrl_d.ext_irq_flag & ctrl_d.ext_irq_enable) |
         (ctrl_d.timer_overflow_flag & ctrl_d.timer_overflow_enable) |
         (ctrl_d.port_change_flag & ctrl_d.port_change_enable));
      // only the return address goes to the stack
      core_out.push_valid <= core_in.irq_ack;
      if (core_in.irq_ack) begin
        core_out.push_pc <= core_in.ret_pc;
      end
    end
  end

  // ---------------- sleep and wake
  assign wake_now = (slp_q == ICL_ASLEEP) & armed_q & ext_edge;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slp_q <= ICL_AWAKE;
      armed_q <= 1'b0;
      core_out.wake <= 1'b0;
      core_out.to_vector <= 1'b0;
    end else begin
      core_out.wake <= 1'b0;
      case (slp_q)
        ICL_AWAKE: begin
          if (core_in.sleep) begin
            armed_q <= ctrl_q.ext_irq_enable;
            slp_q <= ICL_ASLEEP;
          end
        end
        ICL_ASLEEP: begin
          if (wake_now) begin
            core_out.wake <= 1'b1;
            core_out.to_vector <= ctrl_q.global_irq_enable;
            slp_q <= ICL_AWAKE;
          end else if (!core_in.sleep) begin
            slp_q <= ICL_AWAKE;
          end
        end
        default: slp_q <= ICL_AWAKE;
      endcase
    end
  end

  // ---------------- event status, mask, interrupt line
  always_comb begin
    evt_set = '0;
    evt_set[`ICL_EV_EXT] = ext_edge;
    evt_set[`ICL_EV_TOV] = tmr_ovf;
    evt_set[`ICL_EV_PCH] = port_chg;
    evt_set[`ICL_EV_WAKE] = wake_now;
    evt_d = evt_q;
    if (wr_ok && wr_idx == 3'h3) begin
      evt_d = evt_q & ~w_byte_q[`ICL_EV_W-1:0];
    end
    evt_d = evt_d | evt_set;
    mask_d = mask_q;
    if (wr_ok && wr_idx == 3'h4) begin
      mask_d = w_byte_q[`ICL_EV_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evt_q <= '0;
      mask_q <= `ICL_MASK_RST;
      irq <= 1'b0;
    end else begin
      evt_q <= evt_d;
      mask_q <= mask_d;
      irq <= |(evt_d & mask_d);
    end
  end

endmodule

// file: tb/icl_properties.sv
`timescale 1ns/10ps

module icl_checker
  import icl_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic rst, // async reset
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic s_axi_rvalid, // r valid
  input wire icl_pkg::icl_core_in_t core_in, // from core
  input wire icl_pkg::icl_core_out_t core_out // to core
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence push_step;
    core_out.push_valid ##1 !core_out.push_valid;
  endsequence
  sequence wake_step;
    core_out.wake ##1 !core_out.wake;
  endsequence

  a_push_on_ack: assert property (core_in.irq_ack |=> push_step)
    else $error("push missing after ack");
  a_push_pc: assert property (core_in.irq_ack |=>
    core_out.push_pc == $past(core_in.ret_pc))
    else $error("pushed pc differs");
  a_ack_drops_req: assert property (core_in.irq_ack &&
    !core_in.retfie |=> !core_out.irq_req)
    else $error("request stays after ack");
  a_wake_asleep: assert property (core_out.wake |->
    $past(core_in.sleep) ##0 wake_step)
    else $error("bad wake pulse");
  a_vector_hold: assert property ($changed(core_out.to_vector) |->
    core_out.wake)
    else $error("vector flag moved without wake");
  a_wr_answer: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
    else $error("write not answered");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid)
    else $error("read not answered");
  a_rd_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  a_wr_refuse: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
endmodule

bind icl_top icl_checker i_icl_checker (.clk(clk), .rst(rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .core_in(core_in), .core_out(core_out));

// file: tb/icl_core_model.sv
`timescale 1ns/10ps

module icl_core_model
  import icl_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic rst, // async reset
  input wire icl_pkg::icl_core_out_t core_out, // from block
  input wire logic go_sleep, // enter sleep
  input wire logic go_awake, // leave sleep quietly
  input wire logic go_ret, // return from service
  output icl_pkg::icl_core_in_t core_in // to block
);
  logic in_isr_q;
  logic [12:0] pc_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_in <= '0;
      in_isr_q <= 1'b0;
      pc_q <= 13'h0100;
    end else begin
      pc_q <= pc_q + 13'h0001;
      core_in.retfie <= go_ret;
      core_in.irq_ack <= 1'b0;
      core_in.ret_pc <= ~pc_q;
      if (go_ret) begin
        in_isr_q <= 1'b0;
      end
      if (core_out.irq_req && !in_isr_q && !core_in.sleep &&
          !core_in.irq_ack) begin
        core_in.irq_ack <= 1'b1;
        core_in.ret_pc <= pc_q;
        in_isr_q <= 1'b1;
      end
      if (core_out.wake || go_awake) begin
        core_in.sleep <= 1'b0;
      end else if (go_sleep) begin
        core_in.sleep <= 1'b1;
      end
    end
  end
endmodule

// file: tb/icl_top_tb.sv
`timescale 1ns/10ps

module icl_top_tb;
  import icl_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] awa = 5'h00;
  logic awv = 1'b0;
  logic [31:0] wd = 32'h0;
  logic wv = 1'b0;
  logic [4:0] ara = 5'h00;
  logic arv = 1'b0;
  logic pin = 1'b1;
  logic [3:0] port = 4'h0;
  logic gs = 1'b0;
  logic ga = 1'b0;
  logic gr = 1'b0;
  logic awr, wrd, bv, arr, rv, irq, vec;
  logic [1:0] br, rr, r;
  logic [31:0] rd, d;
  logic [12:0] pc_seen;
  icl_core_in_t cin;
  icl_core_out_t cout;
  int failures = 0;
  int total_checks = 0;
  int pushes = 0;
  int wakes = 0;

  always #4 clk = ~clk;

  icl_top i_icl_top (.clk(clk), .rst(rst), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(1'b1), .ext_irq_pin(pin), .upper_port_pins(port),
    .core_in(cin), .core_out(cout), .irq(irq));

  icl_core_model i_icl_core_model (.clk(clk), .rst(rst), .core_out(cout),
    .go_sleep(gs), .go_awake(ga), .go_ret(gr), .core_in(cin));

  always @(posedge clk) begin
    if (cout.push_valid) begin
      pushes++;
    end
    if (cin.irq_ack) begin
      pc_seen <= cin.ret_pc;
    end
    if (cout.wake) begin
      wakes++;
      vec <= cout.to_vector;
    end
  end

  task automatic summarize;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wreg(input logic [4:0] a, input logic [31:0] v);
    int n;
    @(posedge clk);
    awa <= a;
    awv <= 1'b1;
    wd <= v;
    wv <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrd) wv <= 1'b0;
      if (bv === 1'b1) break;
    end
    r = br;
    if (n == 40) failures++;
  endtask

  task automatic rchk(input logic [4:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    int n;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (rv === 1'b1) break;
    end
    d = rd;
    r = rr;
    if (n == 40) failures++;
    chk(d & m, e);
  endtask

  task automatic t_reset;
    rchk(5'h00, 32'hFF, 32'h00);
    rchk(5'h04, 32'hFF, 32'h41);
    rchk(5'h10, 32'hFF, 32'h00);
    rchk(5'h18, 32'hFFFFFFFF, 32'h0);
    chk(r, 2'h2);
    wreg(5'h18, 32'hFF);
    chk(r, 2'h2);
    wreg(5'h10, 32'h0);
    chk(r, 2'h0);
  endtask

  task automatic t_ext;
    wreg(5'h04, 32'h40);
    wreg(5'h00, 32'h00);
    pin <= 1'b0;
    settle(8);
    rchk(5'h00, 32'h02, 32'h00);
    pin <= 1'b1;
    settle(8);
    rchk(5'h00, 32'h02, 32'h02);
    settle(20);
    rchk(5'h00, 32'h02, 32'h02);
    wreg(5'h04, 32'h00);
    wreg(5'h00, 32'h00);
    pin <= 1'b0;
    settle(8);
    rchk(5'h00, 32'h02, 32'h02);
  endtask

  task automatic t_timer;
    wreg(5'h00, 32'h00);
    wreg(5'h08, 32'hF0);
    rchk(5'h08, 32'hFF, 32'hF0);
    wreg(5'h04, 32'h01);
    rchk(5'h00, 32'h04, 32'h00);
    settle(20);
    rchk(5'h00, 32'h04, 32'h04);
    wreg(5'h04, 32'h00);
  endtask

  task automatic t_port;
    int i;
    for (i = 0; i < 4; i++) begin
      wreg(5'h00, 32'h00);
      port <= port ^ (4'h1 << i);
      settle(8);
      rchk(5'h00, 32'h01, 32'h01);
    end
    wreg(5'h00, 32'h00);
    settle(8);
    rchk(5'h00, 32'h01, 32'h00);
  endtask

  task automatic t_irq;
    wreg(5'h0C, 32'hF);
    wreg(5'h10, 32'h1);
    settle(2);
    chk(irq, 1'b0);
    pin <= 1'b1;
    settle(8);
    pin <= 1'b0;
    settle(8);
    chk(irq, 1'b1);
    rchk(5'h0C, 32'hF, 32'h1);
    wreg(5'h10, 32'h0);
    settle(2);
    chk(irq, 1'b0);
    wreg(5'h10, 32'h1);
    settle(2);
    chk(irq, 1'b1);
    wreg(5'h0C, 32'h1);
    settle(2);
    chk(irq, 1'b0);
  endtask

  task automatic t_core;
    logic [7:0] en[6] = '{8'h92, 8'hA4, 8'h89, 8'h82, 8'h84, 8'h81};
    int i;
    int p;
    for (i = 0; i < 6; i++) begin
      p = pushes;
      wreg(5'h00, {24'h0, en[i]});
      settle(6);
      chk(pushes - p, i < 3);
      if (i < 3) chk(cout.push_pc, pc_seen);
      wreg(5'h00, 32'h00);
      if (i < 3) begin
        gr <= 1'b1;
        @(posedge clk);
        gr <= 1'b0;
      end
    end
  endtask

  task automatic t_sleep;
    int i;
    int w;
    for (i = 0; i < 3; i++) begin
      w = wakes;
      wreg(5'h00, i == 0 ? 32'h00 : (i == 1 ? 32'h10 : 32'h90));
      gs <= 1'b1;
      @(posedge clk);
      gs <= 1'b0;
      pin <= 1'b1;
      settle(6);
      pin <= 1'b0;
      settle(12);
      chk(wakes - w, i > 0);
      if (i > 0) chk(vec, i == 2);
      if (i == 0) rchk(5'h14, 32'h3, 32'h1);
      wreg(5'h00, 32'h00);
      ga <= 1'b1;
      @(posedge clk);
      ga <= 1'b0;
      if (i == 2) begin
        gr <= 1'b1;
        @(posedge clk);
        gr <= 1'b0;
      end
    end
  endtask

  initial begin
    settle(3);
    rst <= 1'b0;
    t_reset;
    t_ext;
    t_timer;
    t_port;
    t_irq;
    t_core;
    t_sleep;
    summarize;
  end

  initial begin
    settle(20000);
    failures++;
    summarize;
  end
endmodule
